// ===== shared/tcpc_defs.svh
// Summary of operation
// - clamp applies firmware-selected limit, active only while the path sources power
// - clamped overcurrent lasting past the deglitch interval latches the switch off
// - overcurrent-protection trip on a closed switch latches that switch off
// - vbus above overvoltage or below undervoltage limit disables the path
// - reverse current: comparator mode as source, ideal diode as sink, switch off
// - external path controls are active high and drop on overvoltage or undervoltage
// - overcurrent never acts on the external path controls
// - vconn switch feeds one cc pin with a 600 mA limit
// - vconn closes only with input good at enable, then stays closed
// - both switches off and vbus above safe 5 V enables pull-down until safe 5 V
// - for safe 0 V the pull-down stays on until vbus reaches it, timed
// - dfp, both pins open: monitor both, no vbus nor vconn
// - dfp, Rd on one pin: apply vbus, no vconn, watch only the Rd pin
// - dfp, Ra on one pin: no power, watch open pin attach and Ra detach
// - dfp, Ra and Rd: vbus plus vconn on Ra pin, watch only Rd pin
// - dfp, Rd-Rd is debug, Ra-Ra is audio accessory; either pin detaches
// - dfp advertised current is one of four levels
// - detach uses the disconnect threshold matching the advertised current
// - ufp: pull-down on both pins, attach by vbus, partner current from cc
// - drp alternates cc pins between pull-down and pull-up
// - sink with swap enabled flags a cc drop, then stops sinking and sources
// - source with swap enabled signals by pull-down, then becomes a sink
`ifndef TCPC_DEFS_SVH
`define TCPC_DEFS_SVH
`define TCPC_CLK_MHZ        40
`define TCPC_OCC_DGL_US     10
`define TCPC_OCC_DGL_CYC    (`TCPC_OCC_DGL_US * `TCPC_CLK_MHZ)
`define TCPC_SAFE0_US       1000
`define TCPC_SAFE0_CYC      (`TCPC_SAFE0_US * `TCPC_CLK_MHZ)
`define TCPC_DRP_US         1000
`define TCPC_DRP_CYC        (`TCPC_DRP_US * `TCPC_CLK_MHZ)
`define TCPC_VCONN_ILIM_MA  10'h258
`define TCPC_A_CTRL         8'h00
`define TCPC_A_CFG          8'h04
`define TCPC_A_STAT         8'h08
`define TCPC_A_EVT          8'h0c
`define TCPC_CTRL_RST       32'h0000_0000
`define TCPC_CFG_RST        32'h0000_0000
`define TCPC_C_EN           1:0
`define TCPC_C_SRC          3:2
`define TCPC_C_EXT          5:4
`define TCPC_C_VCONN        6
`define TCPC_C_ROLE         8:7
`define TCPC_C_ADV          10:9
`define TCPC_C_FRS          11
`define TCPC_C_SAFE0        12
`define TCPC_C_WMASK        32'h0000_1fff
`define TCPC_C_FRSSIG       13
`define TCPC_C_CLR          15:14
`define TCPC_F_CLAMP        3:0
`define TCPC_F_OV           11:4
`define TCPC_F_UV           19:12
`define TCPC_F_WMASK        32'h000f_ffff
`define TCPC_E_FRS          0
`define TCPC_E_TMO          1
`endif

// ===== shared/tcpc_pkg.sv
package tcpc_pkg;
    typedef enum logic [1:0] {CC_OPEN, CC_RA, CC_RD} tcpc_cc_t;
    typedef enum logic [1:0] {ROLE_DFP, ROLE_UFP, ROLE_DRP} tcpc_role_t;
    typedef enum logic [2:0] {
        ATT_NONE, ATT_UFP, ATT_CABLE, ATT_CABLE_UFP, ATT_DEBUG, ATT_AUDIO, ATT_SINK
    } tcpc_att_t;
endpackage

// ===== hw/tcpc_sync.sv
`timescale 1ns/1ps
module tcpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end

    assign q = q_r;
endmodule // tcpc_sync

// ===== hw/tcpc_port_ctrl.sv
`timescale 1ns/1ps
`include "tcpc_defs.svh"
module tcpc_port_ctrl #(
    parameter int DGL_CYC   = `TCPC_OCC_DGL_CYC,
    parameter int SAFE0_CYC = `TCPC_SAFE0_CYC,
    parameter int DRP_CYC   = `TCPC_DRP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [1:0]  occ_det,
    input  wire logic [1:0]  ocp_det,
    input  wire logic [1:0]  rev_det,
    input  wire logic        vbus_ov,
    input  wire logic        vbus_uv,
    input  wire logic        vbus_gt_safe5,
    input  wire logic        vbus_gt_safe0,
    input  wire logic        vbus_present,
    input  wire logic        vconn_in_good,
    input  wire logic [1:0]  cc_lt_sink_det,
    input  wire logic [1:0]  cc_lt_cable_det,
    input  wire logic [1:0]  cc_rp_mid,
    input  wire logic [1:0]  cc_rp_high,
    input  wire logic        cc_lt_swap,
    output logic      [1:0]  high_voltage_power_path,
    output logic      [1:0]  clamp_en,
    output logic      [3:0]  clamp_current_limit,
    output logic      [1:0]  rcp_cmp_mode,
    output logic      [7:0]  ov_limit,
    output logic      [7:0]  uv_limit,
    output logic             external_path_control_a,
    output logic             external_path_control_b,
    output logic      [1:0]  vconn_supply_switch,
    output logic      [9:0]  vconn_ilim_ma,
    output logic             vbus_discharge,
    output logic             discharge_to_zero,
    output logic      [1:0]  dfp_pullup_current,
    output logic      [1:0]  adv_current_sel,
    output logic      [1:0]  trimmed_sink_pulldown,
    output logic      [1:0]  role_swap_signal_pulldown
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

    logic [20:0] raw;
    logic [20:0] syn;
    logic [1:0]  occ_s;
    logic [1:0]  ocp_s;
    logic [1:0]  rev_s;
    logic        ov_s;
    logic        uv_s;
    logic        gt5_s;
    logic        gt0_s;
    logic        vbus_s;
    logic        vgood_s;
    logic [1:0]  ccd_s;
    logic [1:0]  cca_s;
    logic [1:0]  rpm_s;
    logic [1:0]  rph_s;
    logic        swap_s;

    assign raw = {occ_det, ocp_det, rev_det, vbus_ov, vbus_uv, vbus_gt_safe5,
                  vbus_gt_safe0, vbus_present, vconn_in_good, cc_lt_sink_det,
                  cc_lt_cable_det, cc_rp_mid, cc_rp_high, cc_lt_swap};

    tcpc_sync #(.W(21)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (raw),
        .q     (syn)
    );

    assign {occ_s, ocp_s, rev_s, ov_s, uv_s, gt5_s, gt0_s, vbus_s, vgood_s,
            ccd_s, cca_s, rpm_s, rph_s, swap_s} = syn;

////////////////////////////////////////////////////////////////////////////////
// register port

    logic [31:0] ctrl_r;
    logic [31:0] cfg_r;
    logic [1:0]  evt_r;
    logic [1:0]  evt_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;
    logic [31:0] stat;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        wr_evt;
    logic [1:0]  clr;
    logic        frs_sig;

    assign wr_ctrl = reg_wr && (reg_addr == `TCPC_A_CTRL);
    assign wr_cfg  = reg_wr && (reg_addr == `TCPC_A_CFG);
    assign wr_evt  = reg_wr && (reg_addr == `TCPC_A_EVT);
    assign clr     = wr_ctrl ? reg_wdata[`TCPC_C_CLR] : 2'h0;
    assign frs_sig = wr_ctrl && reg_wdata[`TCPC_C_FRSSIG];

    always_comb begin
        if (reg_addr == `TCPC_A_CTRL) begin
            rd_mux = ctrl_r;
        end else if (reg_addr == `TCPC_A_CFG) begin
            rd_mux = cfg_r;
        end else if (reg_addr == `TCPC_A_STAT) begin
            rd_mux = stat;
        end else if (reg_addr == `TCPC_A_EVT) begin
            rd_mux = {30'h0, evt_r};
        end else begin
            rd_mux = 32'h0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// configuration decode

    tcpc_pkg::tcpc_role_t role;
    logic [1:0] path_en;
    logic [1:0] path_src;
    logic [1:0] ext_en;
    logic       frs_en;
    logic       safe0_req;
    logic       drp_pu_r;
    logic       dfp_mode;
    logic       snk_mode;

    assign role      = tcpc_pkg::tcpc_role_t'(ctrl_r[`TCPC_C_ROLE]);
    assign path_en   = ctrl_r[`TCPC_C_EN];
    assign path_src  = ctrl_r[`TCPC_C_SRC];
    assign ext_en    = ctrl_r[`TCPC_C_EXT];
    assign frs_en    = ctrl_r[`TCPC_C_FRS];
    assign safe0_req = ctrl_r[`TCPC_C_SAFE0];
    assign dfp_mode  = (role == tcpc_pkg::ROLE_DFP) || ((role == tcpc_pkg::ROLE_DRP) && drp_pu_r);
    assign snk_mode  = (role == tcpc_pkg::ROLE_UFP) || ((role == tcpc_pkg::ROLE_DRP) && !drp_pu_r);

////////////////////////////////////////////////////////////////////////////////
// cc classification and attach state machine

    function automatic tcpc_pkg::tcpc_cc_t cc_class(input logic lt_sink, input logic lt_cable);
        if (!lt_sink)
            return tcpc_pkg::CC_OPEN;
        else if (lt_cable)
            return tcpc_pkg::CC_RA;
        else
            return tcpc_pkg::CC_RD;
    endfunction

    tcpc_pkg::tcpc_cc_t c1;
    tcpc_pkg::tcpc_cc_t c2;
    tcpc_pkg::tcpc_cc_t cmon;
    tcpc_pkg::tcpc_cc_t coth;
    tcpc_pkg::tcpc_att_t att_r;
    tcpc_pkg::tcpc_att_t att_nxt;
    logic pin_r;
    logic pin_nxt;

    // ccd threshold follows adv_current_sel, so open means above the matching level
    assign c1   = cc_class(ccd_s[0], cca_s[0]);
    assign c2   = cc_class(ccd_s[1], cca_s[1]);
    assign cmon = pin_r ? c2 : c1;
    assign coth = pin_r ? c1 : c2;

    always_comb begin
        att_nxt = att_r;
        pin_nxt = pin_r;
        case (att_r)
            tcpc_pkg::ATT_NONE: begin
                if (dfp_mode) begin
                    if (c1 == tcpc_pkg::CC_RD && c2 == tcpc_pkg::CC_RD) begin
                        att_nxt = tcpc_pkg::ATT_DEBUG;
                    end else if (c1 == tcpc_pkg::CC_RA && c2 == tcpc_pkg::CC_RA) begin
                        att_nxt = tcpc_pkg::ATT_AUDIO;
                    end else if ((c1 == tcpc_pkg::CC_RA && c2 == tcpc_pkg::CC_RD) ||
                                 (c1 == tcpc_pkg::CC_RD && c2 == tcpc_pkg::CC_RA)) begin
                        att_nxt = tcpc_pkg::ATT_CABLE_UFP;
                        pin_nxt = (c2 == tcpc_pkg::CC_RD);
                    end else if (c1 == tcpc_pkg::CC_RD || c2 == tcpc_pkg::CC_RD) begin
                        att_nxt = tcpc_pkg::ATT_UFP;
                        pin_nxt = (c2 == tcpc_pkg::CC_RD);
                    end else if (c1 == tcpc_pkg::CC_RA || c2 == tcpc_pkg::CC_RA) begin
                        att_nxt = tcpc_pkg::ATT_CABLE;
                        pin_nxt = (c2 == tcpc_pkg::CC_RA);
                    end
                end else if (snk_mode && vbus_s) begin
                    att_nxt = tcpc_pkg::ATT_SINK;
                    pin_nxt = ccd_s[1];
                end
            end
            tcpc_pkg::ATT_UFP, tcpc_pkg::ATT_CABLE_UFP: begin
                if (cmon == tcpc_pkg::CC_OPEN) begin
                    att_nxt = tcpc_pkg::ATT_NONE;
                end
            end
            tcpc_pkg::ATT_CABLE: begin
                if (cmon == tcpc_pkg::CC_OPEN) begin
                    att_nxt = tcpc_pkg::ATT_NONE;
                end else if (coth == tcpc_pkg::CC_RD) begin
                    att_nxt = tcpc_pkg::ATT_CABLE_UFP;
                    pin_nxt = !pin_r;
                end
            end
            tcpc_pkg::ATT_DEBUG, tcpc_pkg::ATT_AUDIO: begin
                if (c1 == tcpc_pkg::CC_OPEN || c2 == tcpc_pkg::CC_OPEN) begin
                    att_nxt = tcpc_pkg::ATT_NONE;
                end
            end
            tcpc_pkg::ATT_SINK: begin
                if (!vbus_s) begin
                    att_nxt = tcpc_pkg::ATT_NONE;
                end
            end
            default: begin
                att_nxt = tcpc_pkg::ATT_NONE;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// drp toggle, fast role swap, power roles

    logic [19:0] drp_cnt_r;
    logic        drp_tick;
    logic        frs_src_r;
    logic        frs_snk_r;
    logic        frs_det;
    logic        src_att;
    logic        src_act;
    logic        snk_act;

    assign drp_tick = (drp_cnt_r == 20'(DRP_CYC - 1));
    assign src_att  = (att_r == tcpc_pkg::ATT_UFP) || (att_r == tcpc_pkg::ATT_CABLE_UFP);
    assign frs_det  = (att_r == tcpc_pkg::ATT_SINK) && frs_en && swap_s && !frs_src_r;
    assign src_act  = (src_att && !frs_snk_r) || frs_src_r;
    assign snk_act  = ((att_r == tcpc_pkg::ATT_SINK) && !frs_src_r) || frs_snk_r;

////////////////////////////////////////////////////////////////////////////////
// high-voltage paths

    logic [1:0] latch_r;
    logic [1:0] latch_nxt;
    logic [1:0] hv_nxt;
    logic [1:0] hv_r;
    logic [1:0] clamp_r;
    logic [1:0] dgl_done;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_path
            logic [15:0] dgl_cnt_r;
            assign dgl_done[gi] = (dgl_cnt_r == 16'(DGL_CYC));
            // set wins over the firmware clear
            assign latch_nxt[gi] = (latch_r[gi] && !clr[gi]) || dgl_done[gi] ||
                                   (ocp_s[gi] && hv_r[gi]);
            assign hv_nxt[gi] = path_en[gi] && !latch_r[gi] && !ov_s && !uv_s &&
                                !rev_s[gi] && (path_src[gi] ? src_act : snk_act);
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    dgl_cnt_r <= 16'h0;
                end else if (occ_s[gi] && clamp_r[gi] && !dgl_done[gi]) begin
                    dgl_cnt_r <= dgl_cnt_r + 16'h1;
                end else if (!(occ_s[gi] && clamp_r[gi])) begin
                    dgl_cnt_r <= 16'h0;
                end
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// vconn, discharge, terminations

    logic        vconn_want;
    logic        vconn_r;
    logic        vconn_nxt;
    logic        dis_r;
    logic        dis_nxt;
    logic [19:0] z_cnt_r;
    logic        z_tmo;
    logic [1:0]  ptnr_r;
    logic [1:0]  evt_set;

    assign vconn_want = ctrl_r[`TCPC_C_VCONN] && (att_r == tcpc_pkg::ATT_CABLE_UFP) && src_act;
    assign vconn_nxt  = vconn_want && (vconn_r || vgood_s);
    assign dis_nxt    = (hv_r == 2'h0) && (safe0_req ? gt0_s : gt5_s);
    assign z_tmo      = (z_cnt_r == 20'(SAFE0_CYC - 1));
    assign evt_set    = {z_tmo && dis_r && safe0_req, frs_det};
    assign evt_nxt    = (evt_r & ~(wr_evt ? reg_wdata[1:0] : 2'h0)) | evt_set;
    assign stat = {19'h0, drp_pu_r, frs_snk_r, frs_src_r, ptnr_r, dis_r, vconn_r, pin_r,
                   att_r, latch_r};

////////////////////////////////////////////////////////////////////////////////
// state registers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r    <= `TCPC_CTRL_RST;
            cfg_r     <= `TCPC_CFG_RST;
            evt_r     <= 2'h0;
            rdata_r   <= 32'h0;
            att_r     <= tcpc_pkg::ATT_NONE;
            pin_r     <= 1'b0;
            latch_r   <= 2'h0;
            hv_r      <= 2'h0;
            clamp_r   <= 2'h0;
            vconn_r   <= 1'b0;
            dis_r     <= 1'b0;
            ptnr_r    <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata & `TCPC_C_WMASK;
            end
            if (wr_cfg) begin
                cfg_r <= reg_wdata & `TCPC_F_WMASK;
            end
            evt_r     <= evt_nxt;
            rdata_r   <= reg_rd ? rd_mux : 32'h0;
            att_r     <= att_nxt;
            pin_r     <= pin_nxt;
            latch_r   <= latch_nxt;
            hv_r      <= hv_nxt;
            clamp_r   <= hv_nxt & path_src;
            vconn_r   <= vconn_nxt;
            dis_r     <= dis_nxt;
            if (att_r == tcpc_pkg::ATT_SINK) begin
                ptnr_r <= pin_r ? {rph_s[1], rpm_s[1]} : {rph_s[0], rpm_s[0]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drp_cnt_r <= 20'h0;
            drp_pu_r  <= 1'b0;
            frs_src_r <= 1'b0;
            frs_snk_r <= 1'b0;
            z_cnt_r   <= 20'h0;
        end else begin
            if ((role == tcpc_pkg::ROLE_DRP) && (att_r == tcpc_pkg::ATT_NONE)) begin
                drp_cnt_r <= drp_tick ? 20'h0 : drp_cnt_r + 20'h1;
                drp_pu_r  <= drp_pu_r ^ drp_tick;
            end
            if (att_nxt == tcpc_pkg::ATT_NONE || !frs_en) begin
                frs_src_r <= 1'b0;
                frs_snk_r <= 1'b0;
            end else begin
                frs_src_r <= frs_src_r || frs_det;
                frs_snk_r <= frs_snk_r || (frs_sig && src_act);
            end
            if (dis_r && safe0_req && !z_tmo) begin
                z_cnt_r <= z_cnt_r + 20'h1;
            end else if (!(dis_r && safe0_req)) begin
                z_cnt_r <= 20'h0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// registered outputs

    logic [1:0] pu_r;
    logic [1:0] pd_r;
    logic [1:0] rsw_r;
    logic [1:0] vsw_r;
    logic [1:0] ext_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pu_r  <= 2'h0;
            pd_r  <= 2'h0;
            rsw_r <= 2'h0;
            vsw_r <= 2'h0;
            ext_r <= 2'h0;
        end else begin
            pu_r  <= {2{dfp_mode}};
            pd_r  <= {2{snk_mode}};
            rsw_r <= (frs_snk_r && frs_en) ? (pin_r ? 2'h2 : 2'h1) : 2'h0;
            vsw_r <= vconn_nxt ? (pin_r ? 2'h1 : 2'h2) : 2'h0;
            ext_r <= ext_en & {2{!ov_s && !uv_s}};
        end
    end

    assign reg_rdata                 = rdata_r;
    assign high_voltage_power_path   = hv_r;
    assign clamp_en                  = clamp_r;
    assign clamp_current_limit       = cfg_r[`TCPC_F_CLAMP];
    assign rcp_cmp_mode              = ctrl_r[`TCPC_C_SRC];
    assign ov_limit                  = cfg_r[`TCPC_F_OV];
    assign uv_limit                  = cfg_r[`TCPC_F_UV];
    assign external_path_control_a   = ext_r[0];
    assign external_path_control_b   = ext_r[1];
    assign vconn_supply_switch       = vsw_r;
    assign vconn_ilim_ma             = `TCPC_VCONN_ILIM_MA;
    assign vbus_discharge            = dis_r;
    assign discharge_to_zero         = ctrl_r[`TCPC_C_SAFE0];
    assign dfp_pullup_current        = pu_r;
    assign adv_current_sel           = ctrl_r[`TCPC_C_ADV];
    assign trimmed_sink_pulldown     = pd_r;
    assign role_swap_signal_pulldown = rsw_r;

////////////////////////////////////////////////////////////////////////////////
// checks

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    clamp_src_a: assert property ((clamp_r & ~path_src) == 2'h0)
        else $error("clamp active on a sinking path");
    dgl_latch_a: assert property (dgl_done[0] |=> latch_r[0] ##1 !hv_r[0])
        else $error("deglitched overcurrent did not latch off");
    ocp_off_a: assert property (ocp_s[0] && hv_r[0] |-> ##2 !hv_r[0])
        else $error("overcurrent trip left switch on");
    ovuv_off_a: assert property ((ov_s || uv_s) |=> hv_r == 2'h0)
        else $error("path on during ov or uv");
    rev_off_a: assert property (rev_s[0] |=> !hv_r[0])
        else $error("path on with reverse current");
    ext_drop_a: assert property ((ov_s || uv_s) |=> !external_path_control_a && !external_path_control_b)
        else $error("external control held during ov or uv");
    ext_ocp_a: assert property (ext_en[0] && !ov_s && !uv_s && $past(ext_en[0]) |=> external_path_control_a)
        else $error("external control dropped without ov or uv");
    vconn_good_a: assert property ($rose(vconn_r) |-> $past(vgood_s))
        else $error("vconn closed without input good");
    dis_on_a: assert property ((hv_r == 2'h0) && gt5_s && !safe0_req |=> dis_r)
        else $error("discharge missing above safe 5 V");
    none_nopwr_a: assert property (att_r == tcpc_pkg::ATT_NONE |=> vsw_r == 2'h0)
        else $error("vconn applied while detached");
    latch_hold_a: assert property (latch_r[0] && !clr[0] |=> latch_r[0])
        else $error("latch released without clear");

    cov_ufp_c: cover property (att_r == tcpc_pkg::ATT_NONE ##1 att_r == tcpc_pkg::ATT_UFP);
    cov_vconn_c: cover property ($rose(vconn_r));
    cov_latch_c: cover property ($rose(latch_r[0]));
    cov_frs_c: cover property ($rose(frs_src_r));
endmodule // tcpc_port_ctrl

// ===== sim/tcpc_partner_model.sv
`timescale 1ns/1ps
// far-side termination seen through the cc comparators
module tcpc_partner_model (
    input  wire tcpc_pkg::tcpc_cc_t cc1,
    input  wire tcpc_pkg::tcpc_cc_t cc2,
    output logic [1:0]              lt_sink,
    output logic [1:0]              lt_cable
);
    // Rd or Ra pulls the pin below the sink-detect threshold
    assign lt_sink  = {cc2 != tcpc_pkg::CC_OPEN, cc1 != tcpc_pkg::CC_OPEN};
    // only Ra pulls it below the cable threshold
    assign lt_cable = {cc2 == tcpc_pkg::CC_RA, cc1 == tcpc_pkg::CC_RA};
endmodule // tcpc_partner_model

// ===== sim/typec_port_power_attach_control_test.sv
`timescale 1ns/1ps
module typec_port_power_attach_control_test;
    logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdat, d, q;
    logic [1:0] occ = 2'h0, ocp = 2'h0, rev = 2'h0, rpm = 2'h0, rph = 2'h0, hv, vcs, ls, lc;
    logic [1:0] clm, rcm, pu, pd;
    logic ov = 0, uv = 0, s5 = 0, g0 = 0, vp = 0, vg = 1, swp = 0, ea, eb, dis;
    logic [3:0] cl;
    logic [7:0] ovl, uvl;
    logic [9:0] ilim;
    tcpc_pkg::tcpc_cc_t cc1 = tcpc_pkg::CC_OPEN, cc2 = tcpc_pkg::CC_OPEN;
    int err_total = 0, tests_run = 0, ex, ev;
    always #12.5 clk = ~clk;
    tcpc_partner_model far (.cc1(cc1), .cc2(cc2), .lt_sink(ls), .lt_cable(lc));
    tcpc_port_ctrl #(.DGL_CYC(8), .SAFE0_CYC(50), .DRP_CYC(16)) uut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat), .occ_det(occ),
        .ocp_det(ocp), .rev_det(rev), .vbus_ov(ov), .vbus_uv(uv),
        .vbus_gt_safe5(s5), .vbus_gt_safe0(g0), .vbus_present(vp),
        .vconn_in_good(vg), .cc_lt_sink_det(ls), .cc_lt_cable_det(lc),
        .cc_rp_mid(rpm), .cc_rp_high(rph), .cc_lt_swap(swp),
        .high_voltage_power_path(hv), .clamp_en(clm), .clamp_current_limit(cl),
        .rcp_cmp_mode(rcm), .ov_limit(ovl), .uv_limit(uvl),
        .external_path_control_a(ea), .external_path_control_b(eb),
        .vconn_supply_switch(vcs), .vconn_ilim_ma(ilim), .vbus_discharge(dis),
        .discharge_to_zero(), .dfp_pullup_current(pu), .adv_current_sel(),
        .trimmed_sink_pulldown(pd), .role_swap_signal_pulldown());
    ////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = rdat;
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // attach state from the termination pair
    function int att(input int a, input int b);
        if (a == b) return (a == 2) ? 4 : (a == 1) ? 5 : 0;
        if (a == 2 || b == 2) return (a == 1 || b == 1) ? 3 : 1;
        return 2;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        void'($urandom(98690));
        rd(8'h10, d); chk("unmapped", 32'h0, d);
        d = $urandom & 32'h000f_ffff;
        wr(8'h04, d);
        rd(8'h04, q); chk("cfg", d, q);
        chk("clamp", {28'h0, d[3:0]}, {28'h0, cl});
        chk("ovl", {24'h0, d[11:4]}, {24'h0, ovl});
        chk("uvl", {24'h0, d[19:12]}, {24'h0, uvl});
        s5 <= 1'b1;
        w(5); chk("dis", 32'h1, {31'h0, dis});
        s5 <= 1'b0;
        w(5); chk("dis0", 32'h0, {31'h0, dis});
        wr(8'h00, 32'h0000_0075);
        for (int a = 0; a < 3; a++) for (int b = 0; b < 3; b++) begin
            cc1 <= tcpc_pkg::tcpc_cc_t'(a);
            cc2 <= tcpc_pkg::tcpc_cc_t'(b);
            vg <= 1'($urandom);
            w(8);
            rd(8'h08, d);
            ex = att(a, b);
            ev = (ex == 3 && vg) ? ((a == 1) ? 1 : 2) : 0;
            chk("att", ex, {29'h0, d[4:2]});
            if (ex < 4) chk("hv", (ex & 1), {31'h0, hv[0]});
            if (ex < 4) chk("clamp_en", (ex & 1), {30'h0, clm});
            chk("vconn", ev, {30'h0, vcs});
            vg <= 1'b0;
            w(5); chk("vconn_hold", ev, {30'h0, vcs});
            cc1 <= tcpc_pkg::CC_OPEN;
            cc2 <= tcpc_pkg::CC_OPEN;
            w(5);
        end
        cc1 <= tcpc_pkg::CC_RD;
        cc2 <= tcpc_pkg::CC_OPEN;
        w(8); chk("ext", 32'h3, {30'h0, eb, ea});
        chk("terms", 32'h3, {28'h0, pd, pu});
        chk("rcp", 32'h1, {30'h0, rcm});
        chk("ilim", 32'h258, {22'h0, ilim});
        for (int j = 0; j < 3; j++) begin
            {rev[0], uv, ov} <= 3'(1 << j);
            w(5); chk("hv_off", 32'h0, {31'h0, hv[0]});
            chk("ext_off", (j < 2) ? 32'h0 : 32'h3, {30'h0, eb, ea});
            {rev[0], uv, ov} <= 3'h0;
            w(5); chk("hv_back", 32'h1, {31'h0, hv[0]});
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) ocp <= 2'h1;
            else occ <= 2'h1;
            w(k ? 20 : 3);
            ocp <= 2'h0;
            occ <= 2'h0;
            w(6); chk("latch", 32'h0, {31'h0, hv[0]});
            chk("ext_oc", 32'h3, {30'h0, eb, ea});
            wr(8'h00, 32'h0000_c075);
            w(5); chk("clear", 32'h1, {31'h0, hv[0]});
        end
        end_of_test;
    end
endmodule // typec_port_power_attach_control_test
